// ### hdl/bid_core.sv
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1: A long jump loads its 20-bit word target into pc[20:1], pc[0] = 0.
// RULE2: The jump target may be anywhere in the 2 Mbyte space, unpaged.
// RULE3: A long jump always takes exactly two instruction cycles.
// RULE4: Jump cycle one takes low bits in Q2, high bits and pc in Q4.
// RULE5: A jump is a first word with top byte EF and a tail word top F.
// RULE6: An increment has upper six bits 001010, then d, a and f.
// RULE7: The increment adds one and updates carry, half, neg, wrap, zero.
// RULE8: d = 0 writes the accumulator, d = 1 writes the file register.
// RULE9: a = 0 uses the access bank, a = 1 the bank pointer's bank.
// RULE10: Skip-if-nonzero discards the next word on a nonzero result.
// RULE11: Skipping a two-word instruction discards both, three cycles.
// RULE12: Skip-if-zero discards on zero; skipping forms keep all flags.
module bid_core
   import bid_pkg::*;
#(
   parameter int unsigned BANK_W = 4
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);

   localparam int unsigned AW = BANK_W + 8;
   localparam logic [BANK_W-1:0] ACCESS_BANK = '0;

   // ----------------------------------------
   // State
   // ----------------------------------------
   bid_state_type      state_reg, state_next;
   bid_kind_type       kind_reg;
   logic [1:0]         q_reg;
   logic [15:0]        word_reg, word1_reg;
   logic [7:0]         tgt_lo_reg, rd_reg, res_reg, accum_reg;
   logic [20:0]        pc_reg;   // RULE2
   logic [BANK_W-1:0]  bsp_reg;
   logic [AW-1:0]      faddr_reg;
   logic [4:0]         flag_reg;
   logic               skip_reg;
   logic [31:0]        prdata_reg;
   logic               pready_reg, pslverr_reg;
   logic [7:0]         file_mem [2**AW];

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire logic acc      = psel & penable;
   wire logic run      = (state_reg == ST_RUN);
   wire logic hit_ctrl = (paddr == REG_CTRL);
   wire logic hit_ins  = (paddr == REG_INSTR);
   wire logic hit_stat = (paddr == REG_STATUS);
   wire logic hit_acc  = (paddr == REG_ACCUM);
   wire logic hit_pc   = (paddr == REG_PC);
   wire logic hit_fa   = (paddr == REG_FADDR);
   wire logic hit_fd   = (paddr == REG_FDATA);
   wire logic mapped   = hit_ctrl | hit_ins | hit_stat | hit_acc |
                         hit_pc | hit_fa | hit_fd;
   // Writes wait out a running cycle so core and bus never collide
   wire logic wr_ok    = ~pwrite | ~run;
   wire logic done     = acc & pready_reg;
   wire logic bus_wr   = done & pwrite & mapped;
   wire logic instr_wr = bus_wr & hit_ins;

   // ----------------------------------------
   // Instruction decode
   // ----------------------------------------
   wire logic [15:0] new_word = pwdata[15:0];
   wire logic [5:0]  new_op   = new_word[15:10];
   wire logic new_long = (new_word[15:8] == OPC_JUMP_HEAD); // RULE5
   wire bid_kind_type kind_dec =
        (new_op == OPC_INC)     ? K_INC :  // RULE6
        (new_op == OPC_INC_SZ)  ? K_ISZ :
        (new_op == OPC_INC_SNZ) ? K_ISNZ : K_NOP;
   wire logic tail_ok  = (word_reg[15:12] == OPC_JUMP_TAIL); // RULE5
   wire logic inc_any  = (kind_reg == K_INC) | (kind_reg == K_ISZ) |
                         (kind_reg == K_ISNZ);
   wire logic skip_any = (kind_reg == K_ISZ) | (kind_reg == K_ISNZ);
   wire logic ph_q2    = run & (q_reg == PH_Q2);
   wire logic ph_q3    = run & (q_reg == PH_Q3);
   wire logic ph_q4    = run & (q_reg == PH_Q4);
   wire logic to_file  = word_reg[DEST_BIT];
   wire logic [BANK_W-1:0] bank =
        word_reg[BANK_BIT] ? bsp_reg : ACCESS_BANK; // RULE9
   wire logic [AW-1:0] f_addr = {bank, word_reg[7:0]};

   // ----------------------------------------
   // Increment datapath
   // ----------------------------------------
   logic [7:0] inc_y;
   logic       inc_c, inc_hc, inc_z, inc_n, inc_sw;
   logic       inc_c_reg, inc_hc_reg, inc_sw_reg;

   bid_inc_unit u_inc (
      .operand    (rd_reg),
      .result     (inc_y),
      .carry      (inc_c),
      .half_carry (inc_hc),
      .zero       (inc_z),
      .negative   (inc_n),
      .wrap       (inc_sw)
   );

   wire logic res_zero = (res_reg == BYTE_RESET);
   wire logic skip_hit = ph_q4 &
        (((kind_reg == K_ISZ) & res_zero) |       // RULE12
         ((kind_reg == K_ISNZ) & ~res_zero));     // RULE10
   wire logic [20:0] jump_pc = {word_reg[11:0], tgt_lo_reg, 1'b0}; // RULE1
   wire logic [4:0] flag_new;
   assign flag_new[ST_C_BIT]  = inc_c_reg;
   assign flag_new[ST_HC_BIT] = inc_hc_reg;
   assign flag_new[ST_Z_BIT]  = res_zero;
   assign flag_new[ST_SW_BIT] = inc_sw_reg;
   assign flag_new[ST_N_BIT]  = res_reg[7];

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (instr_wr) begin
               state_next = (new_long & ~skip_reg) ? ST_WAIT2 : ST_RUN;
            end
         end
         ST_WAIT2: begin
            if (instr_wr) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (ph_q4 & (kind_reg != K_JUMP1)) begin
               state_next = ST_IDLE; // RULE3
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         q_reg     <= PH_Q1;
      end else begin
         state_reg <= state_next;
         q_reg     <= run ? q_reg + 2'h1 : PH_Q1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kind_reg  <= K_NOP;
         word_reg  <= 16'h0000;
         word1_reg <= 16'h0000;
      end else if (instr_wr) begin
         word_reg  <= new_word;
         word1_reg <= word_reg;
         if (state_reg == ST_WAIT2) begin
            kind_reg <= K_JUMP1;
         end else begin
            kind_reg <= skip_reg ? K_NOP : kind_dec; // RULE10
         end
      end else if (ph_q4 & (kind_reg == K_JUMP1)) begin
         kind_reg <= K_JUMP2; // RULE3
      end
   end

   // Skip flag: a discarded jump head keeps it set for its tail
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         skip_reg <= 1'b0;
      end else if (skip_hit) begin
         skip_reg <= 1'b1;
      end else if (instr_wr & (state_reg == ST_IDLE) & skip_reg) begin
         skip_reg <= new_long; // RULE11
      end
   end

   // ----------------------------------------
   // Q2 read, Q3 process, Q4 write
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tgt_lo_reg <= BYTE_RESET;
         rd_reg     <= BYTE_RESET;
         res_reg    <= BYTE_RESET;
         inc_c_reg  <= 1'b0;
         inc_hc_reg <= 1'b0;
         inc_sw_reg <= 1'b0;
      end else begin
         if (ph_q2) begin
            rd_reg     <= file_mem[f_addr];
            tgt_lo_reg <= word1_reg[7:0]; // RULE4
         end
         if (ph_q3) begin
            res_reg    <= inc_y; // RULE7
            inc_c_reg  <= inc_c;
            inc_hc_reg <= inc_hc;
            inc_sw_reg <= inc_sw;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_reg   <= PC_RESET;
         flag_reg <= 5'h00;
      end else if (ph_q4) begin
         if (kind_reg == K_JUMP1) begin
            pc_reg <= tail_ok ? jump_pc : pc_reg + PC_STEP2; // RULE1 RULE4
         end else if (kind_reg != K_JUMP2) begin
            pc_reg <= pc_reg + PC_STEP;
         end
         if (kind_reg == K_INC) begin
            flag_reg <= flag_new; // RULE7
         end
      end
   end

   // ----------------------------------------
   // Destination and file memory
   // ----------------------------------------
   wire logic core_wf  = ph_q4 & inc_any & to_file;       // RULE8
   wire logic core_wa  = ph_q4 & inc_any & ~to_file;      // RULE8
   wire logic mem_we   = core_wf | (bus_wr & hit_fd);
   wire logic [AW-1:0] mem_wa = core_wf ? f_addr : faddr_reg;
   wire logic [7:0]    mem_wd = core_wf ? res_reg : pwdata[7:0];

   // Data array holds no reset so it maps onto plain RAM
   always_ff @(posedge pclk) begin
      if (mem_we) begin
         file_mem[mem_wa] <= mem_wd;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accum_reg <= BYTE_RESET;
         bsp_reg   <= '0;
         faddr_reg <= '0;
      end else begin
         if (core_wa) begin
            accum_reg <= res_reg;
         end else if (bus_wr & hit_acc) begin
            accum_reg <= pwdata[7:0];
         end
         if (bus_wr & hit_ctrl) begin
            bsp_reg <= pwdata[BANK_W-1:0];
         end
         if (bus_wr & hit_fa) begin
            faddr_reg <= pwdata[AW-1:0];
         end
      end
   end

   // ----------------------------------------
   // Read mux and APB answer
   // ----------------------------------------
   wire logic [7:0] status_val = {state_reg == ST_WAIT2, skip_reg, run,
                                  flag_reg};
   wire logic [31:0] rdata =
        hit_ctrl ? {{(32-BANK_W){1'b0}}, bsp_reg} :
        hit_ins  ? {16'h0000, word_reg} :
        hit_stat ? {24'h00_0000, status_val} :
        hit_acc  ? {24'h00_0000, accum_reg} :
        hit_pc   ? {11'h000, pc_reg} :
        hit_fa   ? {{(32-AW){1'b0}}, faddr_reg} :
        hit_fd   ? {24'h00_0000, file_mem[faddr_reg]} : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= acc & ~pready_reg & wr_ok;
         pslverr_reg <= acc & ~pready_reg & wr_ok & ~mapped;
         if (acc & ~pready_reg & wr_ok & ~pwrite) begin
            prdata_reg <= rdata;
         end
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_jump_pc_load: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
      ph_q4 && kind_reg == K_JUMP1 && tail_ok |=> pc_reg == $past(jump_pc)
   ) else $error("jump target not loaded");

   a_jump_full_range: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      ph_q4 && kind_reg == K_JUMP1 && tail_ok
      |=> pc_reg[20:9] == $past(word_reg[11:0]) && !pc_reg[0]
   ) else $error("jump upper target bits lost");

   a_jump_two_cycles: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
      run && q_reg == PH_Q1 && kind_reg == K_JUMP1
      |-> ##7 run ##1 state_reg == ST_IDLE
   ) else $error("jump not two cycles");

   a_jump_low_capture: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
      ph_q2 && kind_reg == K_JUMP1 |=> tgt_lo_reg == $past(word1_reg[7:0])
   ) else $error("jump low bits not taken in Q2");

   a_jump_head_wait: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
      instr_wr && state_reg == ST_IDLE && !skip_reg && new_long
      |=> state_reg == ST_WAIT2 ##0 !run [*2]
   ) else $error("jump head not held for tail");

   a_inc_decode: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
      instr_wr && state_reg == ST_IDLE && !skip_reg && new_op == OPC_INC
      |=> kind_reg == K_INC && run
   ) else $error("increment not decoded");

   a_inc_flags: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
      ph_q4 && kind_reg == K_INC
      |=> flag_reg[ST_Z_BIT] == $past(res_zero)
          && flag_reg[ST_N_BIT] == $past(res_reg[7])
   ) else $error("increment flags wrong");

   a_dest_accum: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
      ph_q4 && inc_any && !to_file |=> accum_reg == $past(res_reg)
   ) else $error("accumulator not written");

   a_access_bank: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
      ph_q2 && inc_any && !word_reg[BANK_BIT]
      |=> rd_reg == $past(file_mem[{ACCESS_BANK, word_reg[7:0]}])
   ) else $error("access bank not used");

   a_skip_nonzero: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
      ph_q4 && kind_reg == K_ISNZ && !res_zero |=> skip_reg
   ) else $error("nonzero skip not armed");

   a_skip_long: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
      instr_wr && state_reg == ST_IDLE && skip_reg && new_long
      |=> skip_reg && kind_reg == K_NOP
   ) else $error("two-word skip not extended");

   a_skip_flags: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
      ph_q4 && skip_any |=> $stable(flag_reg)
   ) else $error("skipping increment changed flags");

endmodule : bid_core

`default_nettype wire

// ### hdl/bid_pkg.sv
package bid_pkg;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_INSTR  = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_ACCUM  = 8'h0C;
   localparam logic [7:0] REG_PC     = 8'h10;
   localparam logic [7:0] REG_FADDR  = 8'h14;
   localparam logic [7:0] REG_FDATA  = 8'h18;

   // ----------------------------------------
   // Status register bit positions
   // ----------------------------------------
   localparam int ST_C_BIT    = 0;
   localparam int ST_HC_BIT   = 1;
   localparam int ST_Z_BIT    = 2;
   localparam int ST_SW_BIT   = 3;
   localparam int ST_N_BIT    = 4;
   localparam int ST_RUN_BIT  = 5;
   localparam int ST_SKIP_BIT = 6;
   localparam int ST_WAIT_BIT = 7;

   // ----------------------------------------
   // Opcode fields
   // ----------------------------------------
   localparam logic [7:0] OPC_JUMP_HEAD = 8'hEF;
   localparam logic [3:0] OPC_JUMP_TAIL = 4'hF;
   localparam logic [5:0] OPC_INC       = 6'h0A;
   localparam logic [5:0] OPC_INC_SZ    = 6'h0F;
   localparam logic [5:0] OPC_INC_SNZ   = 6'h12;
   localparam int         DEST_BIT      = 9;
   localparam int         BANK_BIT      = 8;

   // ----------------------------------------
   // Phases and reset values
   // ----------------------------------------
   localparam logic [1:0]  PH_Q1      = 2'h0;
   localparam logic [1:0]  PH_Q2      = 2'h1;
   localparam logic [1:0]  PH_Q3      = 2'h2;
   localparam logic [1:0]  PH_Q4      = 2'h3;
   localparam logic [20:0] PC_RESET   = 21'h0_0000;
   localparam logic [20:0] PC_STEP    = 21'h0_0002;
   localparam logic [20:0] PC_STEP2   = 21'h0_0004;
   localparam logic [7:0]  BYTE_RESET = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_WAIT2 = 3'h2,
      ST_RUN   = 3'h4
   } bid_state_type;

   typedef enum logic [5:0] {
      K_NOP   = 6'h01,
      K_INC   = 6'h02,
      K_ISZ   = 6'h04,
      K_ISNZ  = 6'h08,
      K_JUMP1 = 6'h10,
      K_JUMP2 = 6'h20
   } bid_kind_type;

endpackage : bid_pkg

// ### hdl/bid_inc_unit.sv
`timescale 1ns/1ps
`default_nettype none

module bid_inc_unit (
   // Operand
   input  wire logic [7:0] operand,
   // Result and flags
   output logic [7:0]      result,
   output logic            carry,
   output logic            half_carry,
   output logic            zero,
   output logic            negative,
   output logic            wrap
);

   assign {carry, result} = {1'b0, operand} + 9'h001;
   assign half_carry      = &operand[3:0];
   assign zero            = (result == 8'h00);
   assign negative        = result[7];
   // Only 0x7F crosses from positive to negative
   assign wrap            = (operand == 8'h7F);

endmodule : bid_inc_unit

`default_nettype wire

// ### sim/bid_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Program memory model
// ----------------------------------------
// Words are served at once; the bench sets the fetch pace
module bid_prog_mem (
   // Fetch
   input  wire logic [3:0]  idx,
   output logic [15:0]      word
);
   always_comb begin
      case (idx)
         4'h0:    word = 16'h2A05;
         4'h1:    word = 16'h2910;
         4'h2:    word = 16'h4A05;
         4'h3:    word = 16'h2A05;
         4'h4:    word = 16'h3E05;
         4'h5:    word = 16'hEF12;
         4'h6:    word = 16'hF345;
         4'h7:    word = 16'hEFFF;
         4'h8:    word = 16'hFFFF;
         4'h9:    word = 16'hEF34;
         4'hA:    word = 16'hFABC;
         4'hB:    word = 16'hEF56;
         4'hC:    word = 16'h0789;
         default: word = 16'h0000;
      endcase
   end
endmodule : bid_prog_mem

`default_nettype wire

// ### sim/bid_core_test.sv
`timescale 1ns/1ps
`default_nettype none

module bid_core_test
   import bid_pkg::*;
   ;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  pm_idx = 4'h0;
   logic [15:0] pm_word;
   logic [15:0] hw;
   logic [31:0] q;
   logic        serr;
   logic [31:0] bank = 32'h0000_0000;
   int          fails = 0;
   int          total_checks = 0;
   int          n;
   int          n_one;

   always #12.5 pclk = ~pclk;

   // ----------------------------------------
   // Design and program memory
   // ----------------------------------------
   bid_core #(.BANK_W(2)) bid_core_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   bid_prog_mem bid_prog_mem_inst (.idx(pm_idx), .word(pm_word));

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   // Counts access cycles, so stalled writes also measure run length
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output int cnt);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      cnt = 0;
      do begin
         @(posedge pclk);
         cnt++;
      end while (pready !== 1'b1 && cnt < 100);
      q = prdata;
      serr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (cnt >= 100) begin
         fails++;
         $display("MISMATCH pready expected 1 seen 0");
         close_out();
      end
   endtask : apb

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000, n);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, n);
   endtask : wr

   // Fetch one word, then a same-value write that stalls to run end
   task automatic run(input logic [3:0] i);
      pm_idx = i;
      #1;
      wr(REG_INSTR, {16'h0000, pm_word});
      apb(1'b1, REG_CTRL, bank, n);
   endtask : run

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd(REG_STATUS);
      chk("status", 8'h00, q);
      wr(REG_STATUS, 32'h0000_00FF);
      wr(REG_PC, 32'h0000_0100);
      rd(REG_STATUS);
      chk("status ro", 8'h00, q);
      rd(REG_PC);
      chk("pc", 8'h00, q);
      chk("mapped err", 1'b0, serr);
      wr(REG_ACCUM, 32'h0000_005A);
      rd(REG_ACCUM);
      chk("accum bus", 8'h5A, q);
      rd(8'h1C);
      chk("unmapped err", 1'b1, serr);
      chk("unmapped data", 8'h00, q);
      $display("test regs done");
   endtask : t_regs

   task automatic t_bank();
      bank = 32'h0000_0001;
      wr(REG_CTRL, bank);
      wr(REG_FADDR, 12'h110);
      wr(REG_FDATA, 8'h7F);
      wr(REG_FADDR, 12'h010);
      wr(REG_FDATA, 8'h33);
      run(4'h1);
      rd(REG_ACCUM);
      chk("accum", 8'h80, q);
      rd(REG_STATUS);
      chk("flags", 8'h1A, q);
      wr(REG_FADDR, 12'h110);
      rd(REG_FDATA);
      chk("file kept", 8'h7F, q);
      $display("test bank done");
   endtask : t_bank

   // Pointer still 1 here, so a wrong bank shows up
   task automatic t_access();
      wr(REG_FADDR, 12'h005);
      wr(REG_FDATA, 8'hFF);
      run(4'h0);
      n_one = n;
      rd(REG_FDATA);
      chk("file inc", 8'h00, q);
      rd(REG_STATUS);
      chk("flags", 8'h07, q);
      rd(REG_ACCUM);
      chk("accum kept", 8'h80, q);
      rd(REG_PC);
      chk("pc", 8'h04, q);
      $display("test access done");
   endtask : t_access

   task automatic t_skip_nz();
      run(4'h2);
      rd(REG_STATUS);
      chk("skip set", 8'h47, q);
      run(4'h3);
      chk("noop cycles", n_one, n);
      rd(REG_FDATA);
      chk("file", 8'h01, q);
      rd(REG_STATUS);
      chk("skip done", 8'h07, q);
      rd(REG_PC);
      chk("pc", 8'h08, q);
      $display("test skip nonzero done");
   endtask : t_skip_nz

   task automatic t_skip_z();
      wr(REG_FDATA, 8'hFF);
      run(4'h4);
      run(4'h5);
      rd(REG_STATUS);
      chk("skip held", 8'h47, q);
      run(4'h6);
      rd(REG_STATUS);
      chk("skip done", 8'h07, q);
      rd(REG_FDATA);
      chk("file", 8'h00, q);
      rd(REG_PC);
      chk("pc", 8'h0E, q);
      $display("test skip zero done");
   endtask : t_skip_z

   // Condition not met: next word runs, flags still untouched
   task automatic t_no_skip();
      run(4'h4);
      rd(REG_STATUS);
      chk("zero skip idle", 8'h07, q);
      rd(REG_FDATA);
      chk("file", 8'h01, q);
      wr(REG_FDATA, 8'hFF);
      run(4'h2);
      rd(REG_STATUS);
      chk("nonzero skip idle", 8'h07, q);
      run(4'h3);
      rd(REG_FDATA);
      chk("next runs", 8'h01, q);
      rd(REG_STATUS);
      chk("inc flags", 8'h00, q);
      rd(REG_PC);
      chk("pc", 8'h14, q);
      $display("test no skip done");
   endtask : t_no_skip

   // Top target first, then an ordinary one
   task automatic t_jump();
      for (int k = 0; k < 2; k++) begin
         run(4'(7 + 2 * k));
         hw = pm_word;
         rd(REG_STATUS);
         chk("tail wait", 1'b1, q[7]);
         run(4'(8 + 2 * k));
         chk("jump cycles", n_one + 4, n);
         rd(REG_PC);
         chk("pc", {pm_word[11:0], hw[7:0], 1'b0}, q);
      end
      run(4'hB);
      run(4'hC);
      rd(REG_PC);
      chk("bad tail pc", 32'h0015_786C, q);
      rd(REG_INSTR);
      chk("last word", 32'h0000_0789, q);
      $display("test jump done");
   endtask : t_jump

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_bank();
      t_access();
      t_skip_nz();
      t_skip_z();
      t_no_skip();
      t_jump();
      close_out();
   end
endmodule : bid_core_test

`default_nettype wire
